// [inc/qdc_pkg.sv]
// Purpose: Shared constants and types for the quad converter command decoder
// Assumes: 24-bit frames, four channels, 18-bit channel registers
// Notes:   Register map indices are word addresses on the plain register port

package qdc_pkg;

    // ==================================================================
    // Frame layout
    localparam int FRAME_W = 24;
    localparam int DATA_W = 16;
    localparam int CHAN_W = 18;
    localparam int NUM_CHAN = 4;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] FRAME_LAST_BIT = 5'h17;
    localparam int ADDR_HI_POS = 23;
    localparam int ADDR_LO_POS = 22;
    localparam int LOAD_HI_POS = 21;
    localparam int LOAD_LO_POS = 20;
    localparam int SEL_HI_POS = 18;
    localparam int SEL_LO_POS = 17;
    localparam int PD_FLAG_POS = 16;
    localparam int PD_CODE_HI_POS = 15;
    localparam int PD_CODE_LO_POS = 14;
    localparam int PD_LOW_W = 14;

    // ==================================================================
    // Load control encodings {load_ctrl_hi, load_ctrl_lo}
    localparam logic [1:0] LOAD_STORE = 2'h0;
    localparam logic [1:0] LOAD_SINGLE = 2'h1;
    localparam logic [1:0] LOAD_ALL = 2'h2;
    localparam logic [1:0] LOAD_BCAST = 2'h3;

    // ==================================================================
    // Power-down condition held in channel bits 17:16
    localparam logic [1:0] PD_NONE = 2'h0;
    localparam logic [1:0] PD_1K = 2'h1;
    localparam logic [1:0] PD_100K = 2'h2;
    localparam logic [1:0] PD_HIZ = 2'h3;

    // ==================================================================
    // Register port
    localparam int REG_AW = 4;
    localparam int REG_DW = 32;
    localparam logic [REG_AW-1:0] REG_CTRL = 4'h0;
    localparam logic [REG_AW-1:0] REG_STATUS = 4'h1;
    localparam logic [REG_AW-1:0] REG_LAST_FRAME = 4'h2;
    localparam logic [REG_AW-1:0] REG_OUT_BASE = 4'h4;
    localparam logic [REG_AW-1:0] REG_HOLD_BASE = 4'h8;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_CLR_BIT = 1;
    localparam logic CTRL_EN_RESET = 1'b1;
    localparam int STAT_CNT_W = 8;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SHIFT,
        ST_LOCKED
    } qdc_state_e;

endpackage : qdc_pkg

// [inc/qdc_chan_if.sv]
// Purpose: Carries write and load commands to the channel bank and its contents back
// Assumes: Single clock domain shared by decoder and bank
// Notes:   Commands are one-cycle pulses

`timescale 1ns/1ps

interface qdc_chan_if;
    import qdc_pkg::*;

    logic [NUM_CHAN-1:0] wr_en;
    logic [NUM_CHAN-1:0] load;
    logic [CHAN_W-1:0] wr_word;
    logic [CHAN_W-1:0] hold [NUM_CHAN];
    logic [CHAN_W-1:0] outr [NUM_CHAN];

    modport decoder (output wr_en, output load, output wr_word, input hold, input outr);
    modport bank (input wr_en, input load, input wr_word, output hold, output outr);
endinterface : qdc_chan_if

// [design/qdc_chan_bank.sv]
// Purpose: Holding and output registers of the four channels
// Assumes: Commands arrive as one-cycle pulses from the decoder
// Notes:   A write and a load to one channel in one cycle loads the new word

`timescale 1ns/1ps

module qdc_chan_bank
    import qdc_pkg::*;
(
    // Clock, reset and clock enable
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // Command side
    qdc_chan_if.bank chan
);

    // ==================================================================
    // Channel storage
    logic [CHAN_W-1:0] hold_r [NUM_CHAN];
    logic [CHAN_W-1:0] out_r [NUM_CHAN];

    for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
        // Holding register: new word only on write
        always_ff @(posedge clk_i) begin
            if (!reset_n_i) begin
                hold_r[g] <= '0;
            end else if (ce_i && chan.wr_en[g]) begin
                hold_r[g] <= chan.wr_word;
            end
        end

        // Output register zero at power-up, kept until next load
        always_ff @(posedge clk_i) begin
            if (!reset_n_i) begin
                out_r[g] <= '0;
            end else if (ce_i && chan.load[g]) begin
                // Same-cycle write bypasses the holding copy
                out_r[g] <= chan.wr_en[g] ? chan.wr_word : hold_r[g];
            end
        end

        assign chan.hold[g] = hold_r[g];
        assign chan.outr[g] = out_r[g];
    end

endmodule : qdc_chan_bank

// [design/qdc_decoder.sv]
// Purpose: Serial frame receiver and command decoder of a quad 16-bit converter
// Assumes: Link pins are asynchronous to clk_i and are resynchronised here
// Notes:   Link clock must be well below half the system clock rate
//
// Strobed register access and the placing of the registers were decided locally.

`timescale 1ns/1ps

// Operation
// RULE1: Data shifted MSB first on falling serial clock while select low; decode at 24th.
// RULE2: Select rising before 24th edge discards frame and changes nothing.
// RULE3: Non-broadcast frames ignored unless address bits match address pins.
// RULE4: Output registers hold zero after power-up until loaded.
// RULE5: Top two frame bits pick one of four devices on the bus.
// RULE6: Store mode without power-down writes data to selected holding register only.
// RULE7: Store mode with power-down writes code to selected holding register; low bits zero. Code zeroes only bits 15:14 and keeps frame bits 13:0.
// RULE8: Single mode writes data to selected channel and loads its output.
// RULE9: Single mode with power-down writes code and loads that channel.
// RULE10: Load-all mode writes selected channel data and loads every output.
// RULE11: Load-all mode with power-down writes code and loads every output.
// RULE12: Broadcast with select-high zero loads all outputs from holding, any address.
// RULE13: Broadcast with select-high one writes data to all channels and loads all.
// RULE14: Broadcast with power-down applies the code to all channels, any address. Code writes it only with select-high one; select-high zero loads from holding.
// RULE15: Channel registers are 18 bits: 16 data, two power-down condition.
// RULE16: With power-down flag, frame bits 15:14 go to channel bits 17:16.
// RULE17: Codes 100 and 111 open output, 101 1k, 110 100k to ground.
// RULE18: Power-down acts only once loaded into the output register.
// RULE19: Power-down conditions follow every load mode like data.
// RULE20: Powered-down channel disconnects amplifier, connects chosen resistor or opens.
// RULE21: Channel leaves power-down only by loading data written without the flag.
// RULE22: Frame bit 19 is ignored.
// RULE23: Output registers keep their contents until a later load.
module qdc_decoder
    import qdc_pkg::*;
(
    // Clock, reset and freeze
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // Serial link pins
    input wire logic sync_n_i,
    input wire logic sclk_i,
    input wire logic din_i,
    // Device address straps
    input wire logic device_addr_hi_i,
    input wire logic device_addr_lo_i,
    // Register port
    input wire logic [REG_AW-1:0] reg_addr_i,
    input wire logic [REG_DW-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [REG_DW-1:0] reg_rdata_o,
    // Channel outputs
    output logic [NUM_CHAN*DATA_W-1:0] chan_code_o,
    output logic [NUM_CHAN*2-1:0] chan_pd_o,
    output logic [NUM_CHAN-1:0] amp_connect_o,
    output logic [NUM_CHAN-1:0] gnd_1k_o,
    output logic [NUM_CHAN-1:0] gnd_100k_o,
    output logic frame_done_o
);

    // ==================================================================
    // Helper functions

    // Maps frame code bits to the stored condition; 00 shares open-output with 11
    function automatic logic [1:0] pd_cond(input logic [1:0] code);
        pd_cond = (code == PD_NONE) ? PD_HIZ : code;
    endfunction : pd_cond

    // One-hot channel mask from the two select bits
    function automatic logic [NUM_CHAN-1:0] chan_mask(input logic [1:0] sel);
        chan_mask = NUM_CHAN'(1) << sel;
    endfunction : chan_mask

    // ==================================================================
    // Pin synchronisers
    logic [1:0] sync_n_meta_r;
    logic [1:0] sclk_meta_r;
    logic [1:0] din_meta_r;
    logic [1:0] addr_meta_r;
    logic [1:0] addr_s_r;
    logic sync_n_s_r;
    logic sclk_s_r;
    logic din_s_r;
    logic sclk_d_r;

    // Two flops per pin; first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            sync_n_meta_r <= 2'h3;
            sclk_meta_r <= 2'h0;
            din_meta_r <= 2'h0;
            addr_meta_r <= 2'h0;
        end else if (ce_i) begin
            sync_n_meta_r <= {sync_n_meta_r[0], sync_n_i};
            sclk_meta_r <= {sclk_meta_r[0], sclk_i};
            din_meta_r <= {din_meta_r[0], din_i};
            addr_meta_r <= {addr_meta_r[0], device_addr_hi_i};
        end
    end

    logic [1:0] addr_lo_meta_r;

    // Second address strap, same two-stage treatment
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            addr_lo_meta_r <= 2'h0;
        end else if (ce_i) begin
            addr_lo_meta_r <= {addr_lo_meta_r[0], device_addr_lo_i};
        end
    end

    // Resynchronised levels and previous clock level for edge finding
    assign sync_n_s_r = sync_n_meta_r[1];
    assign sclk_s_r = sclk_meta_r[1];
    assign din_s_r = din_meta_r[1];
    assign addr_s_r = {addr_meta_r[1], addr_lo_meta_r[1]};

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            sclk_d_r <= 1'b0;
        end else if (ce_i) begin
            sclk_d_r <= sclk_s_r;
        end
    end

    // ==================================================================
    // Software control
    logic link_en_r;
    logic cnt_clr;
    assign cnt_clr = reg_wr_i && (reg_addr_i == REG_CTRL) && reg_wdata_i[CTRL_CLR_BIT];

    // ==================================================================
    // Frame receiver
    qdc_state_e state_r;
    qdc_state_e state_nxt;
    logic [FRAME_W-2:0] shifter_r;
    logic [FRAME_W-2:0] shifter_nxt;
    logic [CNT_W-1:0] bit_cnt_r;
    logic [CNT_W-1:0] bit_cnt_nxt;
    logic [FRAME_W-1:0] frame_r;
    logic cmd_valid_r;
    logic sclk_fall;
    logic take_bit;
    logic last_bit;
    logic abort;

    assign sclk_fall = sclk_d_r && !sclk_s_r;                                      // [RULE1]
    assign take_bit = sclk_fall && !sync_n_s_r && link_en_r && (state_r != ST_LOCKED);
    assign last_bit = take_bit && (bit_cnt_r == FRAME_LAST_BIT);                   // [RULE1]
    assign abort = sync_n_s_r && (state_r == ST_SHIFT);                            // [RULE2]

    // Next state and shifter; a locked frame ignores further clocks
    always_comb begin
        state_nxt = state_r;
        shifter_nxt = shifter_r;
        bit_cnt_nxt = bit_cnt_r;
        case (state_r)
            ST_IDLE: begin
                if (take_bit) begin
                    state_nxt = ST_SHIFT;
                    shifter_nxt = {shifter_r[FRAME_W-3:0], din_s_r};
                    bit_cnt_nxt = bit_cnt_r + CNT_W'(1);
                end
            end
            ST_SHIFT: begin
                if (abort) begin
                    // Partial frame dropped, only the abort count moves
                    state_nxt = ST_IDLE;                                           // [RULE2]
                    shifter_nxt = '0;
                    bit_cnt_nxt = '0;
                end else if (last_bit) begin
                    state_nxt = ST_LOCKED;
                    bit_cnt_nxt = '0;
                end else if (take_bit) begin
                    shifter_nxt = {shifter_r[FRAME_W-3:0], din_s_r};               // [RULE1]
                    bit_cnt_nxt = bit_cnt_r + CNT_W'(1);
                end
            end
            ST_LOCKED: begin
                // New frame needs select to go high first
                if (sync_n_s_r) begin
                    state_nxt = ST_IDLE;
                    shifter_nxt = '0;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Receiver registers
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state_r <= ST_IDLE;
            shifter_r <= '0;
            bit_cnt_r <= '0;
        end else if (ce_i) begin
            state_r <= state_nxt;
            shifter_r <= shifter_nxt;
            bit_cnt_r <= bit_cnt_nxt;
        end
    end

    // Completed word captured with the 24th bit, decoded next cycle
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            frame_r <= '0;
            cmd_valid_r <= 1'b0;
        end else if (ce_i) begin
            cmd_valid_r <= last_bit;
            if (last_bit) begin
                frame_r <= {shifter_r, din_s_r};                                   // [RULE1]
            end
        end
    end

    // ==================================================================
    // Command decode; bit 19 is never looked at [RULE22]
    logic [1:0] load_ctrl;
    logic [1:0] chan_sel;
    logic powerdown_flag;
    logic addr_match;
    logic bcast;
    logic accept;
    logic [CHAN_W-1:0] cmd_word;
    logic [NUM_CHAN-1:0] sel_mask;
    logic [NUM_CHAN-1:0] all_mask;

    assign load_ctrl = {frame_r[LOAD_HI_POS], frame_r[LOAD_LO_POS]};
    assign chan_sel = {frame_r[SEL_HI_POS], frame_r[SEL_LO_POS]};
    assign powerdown_flag = frame_r[PD_FLAG_POS];
    assign addr_match = ({frame_r[ADDR_HI_POS], frame_r[ADDR_LO_POS]} == addr_s_r); // [RULE3] [RULE5]
    assign bcast = (load_ctrl == LOAD_BCAST);
    assign accept = cmd_valid_r && (bcast || addr_match);                          // [RULE3] [RULE12]
    assign sel_mask = chan_mask(chan_sel);
    assign all_mask = '1;

    // Power-down code lands in bits 17:16, low frame bits kept below
    assign cmd_word = powerdown_flag ?
        {pd_cond(frame_r[PD_CODE_HI_POS:PD_CODE_LO_POS]), 2'h0, frame_r[PD_LOW_W-1:0]} : // [RULE7] [RULE16]
        {PD_NONE, frame_r[DATA_W-1:0]};                                            // [RULE15] [RULE21]

    // Write and load masks per load mode; codes travel exactly like data
    logic [NUM_CHAN-1:0] wr_mask;
    logic [NUM_CHAN-1:0] load_mask;

    always_comb begin
        wr_mask = '0;
        load_mask = '0;
        if (accept) begin
            case (load_ctrl)
                LOAD_STORE: begin
                    wr_mask = sel_mask;                                            // [RULE6] [RULE7] [RULE18]
                end
                LOAD_SINGLE: begin
                    wr_mask = sel_mask;                                            // [RULE8] [RULE9]
                    load_mask = sel_mask;
                end
                LOAD_ALL: begin
                    wr_mask = sel_mask;                                            // [RULE10] [RULE11] [RULE19]
                    load_mask = all_mask;
                end
                default: begin
                    // Broadcast: select-high decides whether frame data is used
                    wr_mask = frame_r[SEL_HI_POS] ? all_mask : '0;                 // [RULE12] [RULE13] [RULE14]
                    load_mask = all_mask;
                end
            endcase
        end
    end

    // ==================================================================
    // Channel bank
    qdc_chan_if chan ();

    assign chan.wr_en = wr_mask;
    assign chan.load = load_mask;
    assign chan.wr_word = cmd_word;

    // Zero at reset and held until loaded [RULE4] [RULE23]
    qdc_chan_bank u_bank (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .chan(chan)
    );

    // ==================================================================
    // Output stage control per channel
    for (genvar g = 0; g < NUM_CHAN; g++) begin : g_out
        logic [1:0] cond;
        assign cond = chan.outr[g][CHAN_W-1:DATA_W];                               // [RULE18]
        assign chan_code_o[g*DATA_W +: DATA_W] = chan.outr[g][DATA_W-1:0];
        assign chan_pd_o[g*2 +: 2] = cond;
        assign amp_connect_o[g] = (cond == PD_NONE);                               // [RULE20]
        assign gnd_1k_o[g] = (cond == PD_1K);                                      // [RULE17] [RULE20]
        assign gnd_100k_o[g] = (cond == PD_100K);                                  // [RULE17]
    end

    assign frame_done_o = accept;

    // ==================================================================
    // Status counters; a same-cycle event counts up from zero after the clear
    logic [STAT_CNT_W-1:0] frame_cnt_r;
    logic [STAT_CNT_W-1:0] abort_cnt_r;

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            frame_cnt_r <= '0;
            abort_cnt_r <= '0;
        end else if (ce_i) begin
            if (accept) begin
                frame_cnt_r <= (cnt_clr ? '0 : frame_cnt_r) + STAT_CNT_W'(1);
            end else if (cnt_clr) begin
                frame_cnt_r <= '0;
            end
            if (ce_i && abort) begin
                abort_cnt_r <= (cnt_clr ? '0 : abort_cnt_r) + STAT_CNT_W'(1);
            end else if (cnt_clr) begin
                abort_cnt_r <= '0;
            end
        end
    end

    // Link enable; cleared stops new bits, a frame in flight just stalls
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            link_en_r <= CTRL_EN_RESET;
        end else if (ce_i && reg_wr_i && (reg_addr_i == REG_CTRL)) begin
            link_en_r <= reg_wdata_i[CTRL_EN_BIT];
        end
    end

    // ==================================================================
    // Register read path, data one cycle after the strobe
    logic [REG_DW-1:0] rd_mux;
    logic [REG_AW-1:0] rd_off;
    assign rd_off = reg_addr_i - REG_OUT_BASE;

    always_comb begin
        rd_mux = '0;
        if (reg_addr_i == REG_CTRL) begin
            rd_mux = REG_DW'(link_en_r);
        end else if (reg_addr_i == REG_STATUS) begin
            rd_mux = REG_DW'({state_r, bit_cnt_r, abort_cnt_r, frame_cnt_r});
        end else if (reg_addr_i == REG_LAST_FRAME) begin
            rd_mux = REG_DW'(frame_r);
        end else if (reg_addr_i >= REG_OUT_BASE && reg_addr_i < REG_HOLD_BASE) begin
            rd_mux = REG_DW'(chan.outr[rd_off[1:0]]);
        end else if (reg_addr_i >= REG_HOLD_BASE && reg_addr_i < REG_HOLD_BASE + REG_AW'(NUM_CHAN)) begin
            rd_mux = REG_DW'(chan.hold[rd_off[1:0]]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= '0;
        end else if (ce_i) begin
            reg_rdata_o <= reg_rd_i ? rd_mux : '0;
        end
    end

endmodule : qdc_decoder

// [test/qdc_host_model.sv]
// Purpose: Serial host model that drives frames into the decoder
// Assumes: Link clock idles high and stands still between frames
// Notes:   Data line shows the inverted last bit once released

`timescale 1ns/1ps

// ==========================================================
// Host serial master
module qdc_host_model (
    // Link pins
    output logic sync_n_o,
    output logic sclk_o,
    output logic din_o
);
    // Idle levels at time zero
    initial begin
        sync_n_o = 1'b1;
        sclk_o = 1'b1;
        din_o = 1'b0;
    end

    // Sends the top n bits of f; fewer than 24 aborts the frame
    task automatic send(input logic [23:0] f, input int n);
        sync_n_o = 1'b0;
        #100;
        for (int i = 23; i > 23 - n; i--) begin
            din_o = f[i];
            #80 sclk_o = 1'b0; // Bit held across the falling edge
            #80 sclk_o = 1'b1;
        end
        #80 sync_n_o = 1'b1;
        din_o = ~din_o; // Released line must not look valid
        #200;
    endtask : send
endmodule : qdc_host_model

// [test/qdc_decoder_sva.sv]
// Purpose: Port-level checks of the command decoder outputs
// Assumes: Single clock domain, synchronous active-low reset
// Notes:   Bound onto every qdc_decoder instance by the bind below

`timescale 1ns/1ps

// ==========================================================
// Checker
module qdc_decoder_sva
    import qdc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Watched outputs
    input wire logic [NUM_CHAN*DATA_W-1:0] chan_code_o,
    input wire logic [NUM_CHAN*2-1:0] chan_pd_o,
    input wire logic [NUM_CHAN-1:0] amp_connect_o,
    input wire logic [NUM_CHAN-1:0] gnd_1k_o,
    input wire logic [NUM_CHAN-1:0] gnd_100k_o,
    input wire logic frame_done_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    logic [NUM_CHAN-1:0] run_w;
    logic [NUM_CHAN-1:0] k1_w;
    logic [NUM_CHAN-1:0] k100_w;

    // Switch settings expected from each stored condition
    for (genvar g = 0; g < NUM_CHAN; g++) begin : g_dec
        assign run_w[g] = chan_pd_o[2*g+:2] == PD_NONE;
        assign k1_w[g] = chan_pd_o[2*g+:2] == PD_1K;
        assign k100_w[g] = chan_pd_o[2*g+:2] == PD_100K;
    end

    // A frame spans far more than eight cycles, so pulses are isolated
    sequence s_done_gap;
        frame_done_o ##1 !frame_done_o [*8];
    endsequence

    a_amp_decode: assert property (amp_connect_o == run_w)
        else $error("amplifier enable disagrees with condition");
    a_gnd_1k: assert property (gnd_1k_o == k1_w)
        else $error("1k switch disagrees with condition");
    a_gnd_100k: assert property (gnd_100k_o == k100_w)
        else $error("100k switch disagrees with condition");
    a_code_hold: assert property (!$stable(chan_code_o) |-> $past(frame_done_o))
        else $error("output code moved without a command");
    a_pd_hold: assert property (!$stable(chan_pd_o) |-> $past(frame_done_o))
        else $error("power-down state moved without a command");
    a_done_pulse: assert property (frame_done_o |-> s_done_gap)
        else $error("command pulse too long or too close");
    a_reset_zero: assert property ($rose(reset_n_i) |-> chan_code_o == '0 && chan_pd_o == '0)
        else $error("outputs not zero after reset");
    a_reset_amp: assert property ($rose(reset_n_i) |-> amp_connect_o == 4'hF)
        else $error("amplifiers not connected after reset");
endmodule : qdc_decoder_sva

bind qdc_decoder qdc_decoder_sva i_qdc_decoder_sva (.clk_i, .reset_n_i, .chan_code_o, .chan_pd_o,
    .amp_connect_o, .gnd_1k_o, .gnd_100k_o, .frame_done_o);

// [test/qdc_decoder_tb_top.sv]
// Purpose: Self-checking bench of the command decoder
// Assumes: Host model drives the link, bench drives the register port
// Notes:   Expected channel state is kept in bench arrays

`timescale 1ns/1ps

// ==========================================================
// Bench top
module qdc_decoder_tb_top import qdc_pkg::*;;
    logic clk = 1'b0;
    logic rst_n, ahi, alo, wr, rd, en, ce;
    logic [REG_AW-1:0] ra;
    logic [REG_DW-1:0] wd, rdata;
    logic [63:0] code;
    logic [7:0] pd;
    logic [3:0] amp, k1, k100;
    logic done;
    wire logic sync_n, sclk, din;
    logic [17:0] mh [4];
    logic [17:0] mo [4];
    logic [23:0] f, lastf;
    int n_fail = 0;
    int checks_done = 0;
    int n_done = 0, n_want = 0;

    always #10 clk = ~clk;

    // Accepted commands seen on the pulse output, an unknown never counts
    always @(posedge clk) if (done === 1'b1) n_done <= n_done + 1;

    qdc_host_model i_qdc_host_model (.sync_n_o(sync_n), .sclk_o(sclk), .din_o(din));
    qdc_decoder i_qdc_decoder (.clk_i(clk), .reset_n_i(rst_n), .ce_i(ce), .sync_n_i(sync_n), .sclk_i(sclk),
        .din_i(din), .device_addr_hi_i(ahi), .device_addr_lo_i(alo), .reg_addr_i(ra), .reg_wdata_i(wd),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .chan_code_o(code), .chan_pd_o(pd),
        .amp_connect_o(amp), .gnd_1k_o(k1), .gnd_100k_o(k100), .frame_done_o(done));

    // ======================================================
    // Checking and register port
    task chk(input logic [63:0] s, input logic [63:0] e);
        checks_done++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %h, expected %h", $time, s, e);
        end
    endtask : chk

    task wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        ra <= a;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data stands only in the cycle after the strobe
    task rd_reg(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        rd <= 1'b1;
        ra <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask : rd_reg

    // ======================================================
    // Expected channel state after one whole frame
    function void apply(logic [23:0] v);
        logic [17:0] w;
        logic [1:0] s;
        lastf = v;
        if (v[21:20] != LOAD_BCAST && v[23:22] != {ahi, alo}) return;
        n_want++;
        s = v[18:17];
        w = v[16] ? {(v[15:14] == 2'h0) ? PD_HIZ : v[15:14], 2'h0, v[13:0]} : {2'h0, v[15:0]};
        if (v[21:20] != LOAD_BCAST) mh[s] = w;
        else if (v[18]) for (int g = 0; g < 4; g++) mh[g] = w;
        if (v[21:20] == LOAD_SINGLE) mo[s] = w;
        else if (v[21:20] != LOAD_STORE) mo = mh;
    endfunction : apply

    task check_all;
        logic [63:0] c;
        logic [7:0] p;
        logic [3:0] a, b, h;
        for (int g = 0; g < 4; g++) begin
            c[16*g+:16] = mo[g][15:0];
            p[2*g+:2] = mo[g][17:16];
            a[g] = mo[g][17:16] == PD_NONE;
            b[g] = mo[g][17:16] == PD_1K;
            h[g] = mo[g][17:16] == PD_100K;
        end
        chk(code, c);
        chk(pd, p);
        chk(amp, a);
        chk(k1, b);
        chk(k100, h);
        chk(n_done, n_want);
        rd_reg(REG_LAST_FRAME, {8'h0, lastf});
        for (int g = 0; g < 4; g++) begin
            rd_reg(REG_HOLD_BASE + 4'(g), {14'h0, mh[g]});
            rd_reg(REG_OUT_BASE + 4'(g), {14'h0, mo[g]});
        end
    endtask : check_all

    // Short frames are aborts and must leave everything alone
    task frame(input logic [23:0] v, input int n);
        i_qdc_host_model.send(v, n);
        if (n == 24 && en) apply(v);
        check_all();
    endtask : frame

    task report_and_stop;
        $display("comparisons %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : report_and_stop

    // ======================================================
    // Main sequence
    initial begin
        {rst_n, ahi, alo, wr, rd, ra, wd, lastf} = '0;
        en = 1'b1;
        ce = 1'b1;
        for (int g = 0; g < 4; g++) {mh[g], mo[g]} = '0;
        void'($urandom(32'hC533));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        check_all();
        $display("test reset done");
        // Every load mode, with and without power-down, bit 19 set
        for (int i = 0; i < 16; i++) frame({2'h0, i[3:2], 1'b1, i[1], i[1], i[0],
            i[0] ? {i[1:0], 14'h0} : 16'hA5C3 + 16'(i)}, 24);
        $display("test modes done");
        frame(24'h26ABCD, 23);
        frame(24'h3F0000, 1);
        rd_reg(REG_STATUS, 32'h0210);
        $display("test abort done");
        wr_reg(REG_CTRL, 32'h0);
        en = 1'b0;
        rd_reg(REG_CTRL, 32'h0);
        frame(24'h1C1234, 24);
        wr_reg(REG_CTRL, 32'h3);
        en = 1'b1;
        rd_reg(REG_CTRL, 32'h1);
        rd_reg(REG_STATUS, 32'h0);
        // Frozen clock enable must swallow the write
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(REG_CTRL, 32'h0);
        ce <= 1'b1;
        rd_reg(REG_CTRL, 32'h1);
        rd_reg(4'h3, 32'h0);
        $display("test registers done");
        // Random traffic across strap settings, with some aborts
        repeat (50) begin
            @(posedge clk);
            ahi <= 1'($urandom);
            alo <= 1'($urandom);
            f = 24'($urandom);
            if (f[16]) f[13:0] = 14'h0;
            @(posedge clk);
            if ($urandom_range(1) == 1) f[23:22] = {ahi, alo};
            frame(f, ($urandom_range(7) == 0) ? int'($urandom_range(23, 1)) : 24);
        end
        $display("test random done");
        report_and_stop();
    end

    // Watchdog, far beyond the expected run length
    initial begin
        #1000000;
        n_fail++;
        report_and_stop();
    end
endmodule : qdc_decoder_tb_top
